// ==== hdl/icf_flag_regs.sv ====
// interrupt control, trap status and request flag registers behind ahb-lite
`default_nettype none
module icf_flag_regs
   import icf_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // request sources, one-cycle pulses in natural order
   input wire logic [31:0] srcEvt,
   // external interrupt pins
   input wire logic [4:0] extIrqPin,
   // trap events from the core, one-cycle pulses
   input wire logic stackFaultEvt,
   input wire logic oscFailEvt,
   input wire logic usbAddrFaultEvt,
   input wire logic dmaAddrFaultEvt,
   input wire logic loopOverflowEvt,
   input wire logic softHardTrapEvt,
   // core status
   input wire logic disableCountdownActive,
   // requests toward the core
   output logic [31:0] irqPending,
   output logic trapPending,
   output logic [4:0] extEdgeSeen
);
   typedef struct packed {
      logic globalIrqEnable;
      logic softTrapEnable;
      logic [4:0] edgePolarity;
      logic usbAddrFault;
      logic dmaAddrFault;
      logic loopOverflow;
      logic softMadeHardTrap;
      logic stackFault;
      logic oscFailure;
      logic [31:0] flags;
      logic [31:0] enables;
      logic [4:0] syncA;
      logic [4:0] syncB;
      logic [4:0] syncC;
      logic [4:0] extEdge;
      logic [31:0] pending;
      logic trapReq;
   } icf_regs_s;

   icf_regs_s st_reg;
   icf_regs_s st_next;
   icf_reg_if rif ();
   logic wrTrap;
   logic wrGlobal;
   logic wrSoft;
   logic wrHard;
   logic wrFlags0;
   logic wrFlags1;
   logic wrEnable0;
   logic wrEnable1;
   logic [4:0] edgeHit;
   logic [31:0] extSet;
   logic [31:0] flagSet;
   logic [31:0] flagBase;
   logic [31:0] enableBase;

   // true when a write strobe targets the given offset
   function automatic logic hits(input logic stb, input logic [11:0] a,
                                 input logic [11:0] ofs);
      hits = stb && (a == ofs);
   endfunction

   // sticky status bit: a set in the same cycle as a clear wins
   function automatic logic sticky(input logic cur, input logic wr,
                                   input logic wval, input logic set);
      logic base;
      base = wr ? wval : cur;
      sticky = base | set;
   endfunction

   // read-back mux; unmapped offsets and unimplemented bits give zero
   function automatic logic [15:0] readback(input logic [11:0] a,
                                            input icf_regs_s s,
                                            input logic disable_countdown_active);
      logic [15:0] v;
      v = 16'h0000;
      if (a == OFS_TRAP_STATUS) begin
         v[BIT_STACK_FAULT] = s.stackFault;
         v[BIT_OSC_FAIL] = s.oscFailure;
      end else if (a == OFS_GLOBAL_EDGE) begin
         v[BIT_GIE] = s.globalIrqEnable;
         v[BIT_DISABLE_COUNTDOWN_ACTIVE] = disable_countdown_active;
         v[BIT_SOFT_TRAP_ENABLE] = s.softTrapEnable;
         v[BIT_EDGE_LO +: NUM_EXT] = s.edgePolarity;
      end else if (a == OFS_SOFT_TRAP) begin
         v[BIT_USB_ADDR] = s.usbAddrFault;
         v[BIT_DMA_ADDR] = s.dmaAddrFault;
         v[BIT_LOOP_OVF] = s.loopOverflow;
      end else if (a == OFS_HARD_TRAP) begin
         v[BIT_SOFT_MADE_HARD_TRAP_FLAG] = s.softMadeHardTrap;
      end else if (a == OFS_FLAGS0) begin
         v = s.flags[15:0];
      end else if (a == OFS_FLAGS1) begin
         v = s.flags[31:16];
      end else if (a == OFS_ENABLE0) begin
         v = s.enables[15:0];
      end else if (a == OFS_ENABLE1) begin
         v = s.enables[31:16];
      end
      readback = v;
   endfunction

   // bus slave that drives the register strobes
   icf_ahb_slave u_slave (
      .clk(clk),
      .rst_n(rst_n),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .rif(rif.bus)
   );

   // read data back to the slave
   assign rif.rdata = readback(rif.addr, st_reg, disableCountdownActive);

   // write decode
   assign wrTrap = hits(rif.wrStb, rif.addr, OFS_TRAP_STATUS);
   assign wrGlobal = hits(rif.wrStb, rif.addr, OFS_GLOBAL_EDGE);
   assign wrSoft = hits(rif.wrStb, rif.addr, OFS_SOFT_TRAP);
   assign wrHard = hits(rif.wrStb, rif.addr, OFS_HARD_TRAP);
   assign wrFlags0 = hits(rif.wrStb, rif.addr, OFS_FLAGS0);
   assign wrFlags1 = hits(rif.wrStb, rif.addr, OFS_FLAGS1);
   assign wrEnable0 = hits(rif.wrStb, rif.addr, OFS_ENABLE0);
   assign wrEnable1 = hits(rif.wrStb, rif.addr, OFS_ENABLE1);

   // edge select per external input on the synchronised level
   always_comb begin
      for (int i = 0; i < NUM_EXT; i++) begin
         if (st_reg.edgePolarity[i]) begin
            edgeHit[i] = ~st_reg.syncB[i] & st_reg.syncC[i];
         end else begin
            edgeHit[i] = st_reg.syncB[i] & ~st_reg.syncC[i];
         end
      end
   end

   // external edges onto their flag positions
   always_comb begin
      extSet = 32'h0000_0000;
      extSet[FLAG_EXT0] = edgeHit[0];
      extSet[FLAG_EXT1] = edgeHit[1];
      extSet[FLAG_EXT2] = edgeHit[2];
   end

   // all set sources of the request flags
   assign flagSet = srcEvt | extSet;

   // software write image of the flag and enable banks
   always_comb begin
      flagBase = st_reg.flags;
      enableBase = st_reg.enables;
      if (wrFlags0) begin
         flagBase[15:0] = rif.wdata;
      end
      if (wrFlags1) begin
         flagBase[31:16] = rif.wdata;
      end
      if (wrEnable0) begin
         enableBase[15:0] = rif.wdata;
      end
      if (wrEnable1) begin
         enableBase[31:16] = rif.wdata;
      end
   end

   // next state of every register
   always_comb begin
      st_next = st_reg;
      // control bits written by software
      if (wrGlobal) begin
         st_next.globalIrqEnable = rif.wdata[BIT_GIE];
         st_next.softTrapEnable = rif.wdata[BIT_SOFT_TRAP_ENABLE];
         st_next.edgePolarity = rif.wdata[BIT_EDGE_LO +: NUM_EXT];
      end
      // trap status bits, set by events, cleared by software
      st_next.stackFault = sticky(st_reg.stackFault, wrTrap,
                                  rif.wdata[BIT_STACK_FAULT], stackFaultEvt);
      st_next.oscFailure = sticky(st_reg.oscFailure, wrTrap,
                                  rif.wdata[BIT_OSC_FAIL], oscFailEvt);
      st_next.usbAddrFault = sticky(st_reg.usbAddrFault, wrSoft,
                                    rif.wdata[BIT_USB_ADDR], usbAddrFaultEvt);
      st_next.dmaAddrFault = sticky(st_reg.dmaAddrFault, wrSoft,
                                    rif.wdata[BIT_DMA_ADDR], dmaAddrFaultEvt);
      st_next.loopOverflow = sticky(st_reg.loopOverflow, wrSoft,
                                    rif.wdata[BIT_LOOP_OVF], loopOverflowEvt);
      st_next.softMadeHardTrap = sticky(st_reg.softMadeHardTrap, wrHard,
                                        rif.wdata[BIT_SOFT_MADE_HARD_TRAP_FLAG], softHardTrapEvt);
      // request flags: a source event beats a software clear
      st_next.flags = flagBase | flagSet;
      st_next.enables = enableBase;
      // pin synchroniser; only the second stage reads the first
      st_next.syncA = extIrqPin;
      st_next.syncB = st_reg.syncA;
      st_next.syncC = st_reg.syncB;
      st_next.extEdge = edgeHit;
      // requests to the core
      st_next.pending = st_reg.globalIrqEnable ?
                        (st_reg.flags & st_reg.enables) : 32'h0000_0000;
      st_next.trapReq = st_reg.stackFault | st_reg.oscFailure |
                        st_reg.softMadeHardTrap |
                        (st_reg.softTrapEnable &
                         (st_reg.usbAddrFault | st_reg.dmaAddrFault |
                          st_reg.loopOverflow));
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg.globalIrqEnable <= RST_GIE;
         st_reg.softTrapEnable <= RST_CTRL;
         st_reg.edgePolarity <= RST_EDGE;
         st_reg.usbAddrFault <= RST_CTRL;
         st_reg.dmaAddrFault <= RST_CTRL;
         st_reg.loopOverflow <= RST_CTRL;
         st_reg.softMadeHardTrap <= RST_CTRL;
         st_reg.stackFault <= RST_CTRL;
         st_reg.oscFailure <= RST_CTRL;
         st_reg.flags <= RST_FLAGS;
         st_reg.enables <= RST_ENABLES;
         st_reg.syncA <= RST_EDGE;
         st_reg.syncB <= RST_EDGE;
         st_reg.syncC <= RST_EDGE;
         st_reg.extEdge <= RST_EDGE;
         st_reg.pending <= RST_FLAGS;
         st_reg.trapReq <= RST_CTRL;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs come straight from flip-flops
   assign irqPending = st_reg.pending;
   assign trapPending = st_reg.trapReq;
   assign extEdgeSeen = st_reg.extEdge;
endmodule : icf_flag_regs
`default_nettype wire

// ==== hdl/icf_pkg.sv ====
// constants shared by the interrupt control and flag register block
`default_nettype none
package icf_pkg;
   // register byte offsets on the bus
   localparam logic [11:0] OFS_TRAP_STATUS = 12'h000;
   localparam logic [11:0] OFS_GLOBAL_EDGE = 12'h004;
   localparam logic [11:0] OFS_SOFT_TRAP = 12'h008;
   localparam logic [11:0] OFS_HARD_TRAP = 12'h00c;
   localparam logic [11:0] OFS_FLAGS0 = 12'h010;
   localparam logic [11:0] OFS_FLAGS1 = 12'h014;
   localparam logic [11:0] OFS_ENABLE0 = 12'h018;
   localparam logic [11:0] OFS_ENABLE1 = 12'h01c;
   // widths
   localparam int unsigned REG_W = 16;
   localparam int unsigned NUM_EXT = 5;
   localparam int unsigned NUM_SRC = 32;
   // field positions
   localparam int unsigned BIT_STACK_FAULT = 2;
   localparam int unsigned BIT_OSC_FAIL = 1;
   localparam int unsigned BIT_GIE = 15;
   localparam int unsigned BIT_DISABLE_COUNTDOWN_ACTIVE = 14;
   localparam int unsigned BIT_SOFT_TRAP_ENABLE = 13;
   localparam int unsigned BIT_EDGE_LO = 0;
   localparam int unsigned BIT_USB_ADDR = 6;
   localparam int unsigned BIT_DMA_ADDR = 5;
   localparam int unsigned BIT_LOOP_OVF = 4;
   localparam int unsigned BIT_SOFT_MADE_HARD_TRAP_FLAG = 0;
   // flag positions of external inputs 0 to 2 within the 32 request flags; inputs 3 and 4 have none
   localparam int unsigned FLAG_EXT0 = 0;
   localparam int unsigned FLAG_EXT1 = 20;
   localparam int unsigned FLAG_EXT2 = 29;
   // reset values
   localparam logic RST_GIE = 1'b1;
   localparam logic RST_CTRL = 1'b0;
   localparam logic [4:0] RST_EDGE = 5'h00;
   localparam logic [31:0] RST_FLAGS = 32'h0000_0000;
   localparam logic [31:0] RST_ENABLES = 32'h0000_0000;
   // ahb encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;
endpackage : icf_pkg
`default_nettype wire

// ==== hdl/icf_reg_if.sv ====
// register access carrier between bus slave and register block
`default_nettype none
interface icf_reg_if;
   logic wrStb;
   logic [11:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   modport bus (output wrStb, output addr, output wdata, input rdata);
   modport regs (input wrStb, input addr, input wdata, output rdata);
endinterface : icf_reg_if
`default_nettype wire

// ==== hdl/icf_ahb_slave.sv ====
// ahb-lite slave that turns bus transfers into register strobes
`default_nettype none
module icf_ahb_slave
   import icf_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // ahb-lite slave side
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // register side
   icf_reg_if.bus rif
);
   typedef enum logic [3:0] {
      ICF_IDLE = 4'h1,
      ICF_WDATA = 4'h2,
      ICF_RWAIT = 4'h4,
      ICF_RDONE = 4'h8
   } icf_bus_e;

   typedef struct packed {
      icf_bus_e phase;
      logic [11:0] addr;
      logic [31:0] rdata;
   } icf_bus_s;

   icf_bus_s st_reg;
   icf_bus_s st_next;
   logic take;

   // a new address phase is accepted whenever the bus is ready
   assign take = hsel & htrans[1] & hready;

   // next state of the slave
   always_comb begin
      st_next = st_reg;
      case (st_reg.phase)
         ICF_RWAIT: begin
            st_next.rdata = {16'h0000, rif.rdata}; // upper half reads zero
            st_next.phase = ICF_RDONE;
         end
         default: begin
            st_next.phase = ICF_IDLE;
            if (take) begin
               st_next.addr = haddr[11:0];
               st_next.phase = hwrite ? ICF_WDATA : ICF_RWAIT;
            end
         end
      endcase
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '{phase: ICF_IDLE, addr: 12'h000, rdata: 32'h0000_0000};
      end else begin
         st_reg <= st_next;
      end
   end

   // strobes toward the register block and bus answers
   assign rif.wrStb = (st_reg.phase == ICF_WDATA);
   assign rif.addr = st_reg.addr;
   assign rif.wdata = hwdata[15:0];
   assign hreadyout = (st_reg.phase != ICF_RWAIT); // one wait state on reads
   assign hresp = HRESP_OKAY;
   assign hrdata = st_reg.rdata;
endmodule : icf_ahb_slave
`default_nettype wire

// ==== verification/icf_props.sv ====
// assertion checker for the interrupt flag register block
`default_nettype none
module icf_props
   import icf_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // events and requests
   input wire logic [4:0] extIrqPin,
   input wire logic [4:0] extEdgeSeen,
   input wire logic stackFaultEvt,
   input wire logic oscFailEvt,
   input wire logic softHardTrapEvt,
   input wire logic trapPending
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic taken;
   logic rdTaken;
   // transfers accepted on this edge
   assign taken = hsel && htrans[1] && hready;
   assign rdTaken = taken && !hwrite;
   hresp_okay_a: assert property (hresp == HRESP_OKAY) else $error("response not okay");
   rdata_upper_a: assert property (hrdata[31:16] == 16'h0000) else $error("upper read bits set");
   write_nowait_a: assert property (taken && hwrite |=> hreadyout) else $error("write stalled");
   read_wait_a: assert property (rdTaken |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
   rdata_hold_a: assert property ($changed(hrdata) |-> $past(rdTaken, 2)) else $error("read data moved");
   hard_trap_a: assert property (stackFaultEvt || oscFailEvt || softHardTrapEvt |-> ##2 trapPending)
      else $error("hard trap not pending");
   // per pin edge detection
   for (genvar i = 0; i < 5; i++) begin : g_edge
      edge_cause_a: assert property (extEdgeSeen[i] |-> $past(extIrqPin[i], 3) != $past(extIrqPin[i], 4))
         else $error("edge seen without pin change");
      edge_single_a: assert property (extEdgeSeen[i] |=> !extEdgeSeen[i]) else $error("edge seen twice");
   end
endmodule // icf_props
`default_nettype wire

// ==== verification/icf_src_model.sv ====
// model of the peripheral sources and core trap lines
`default_nettype none
module icf_src_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // command from the bench
   input wire logic fire,
   input wire logic [31:0] srcSel,
   input wire logic [5:0] trapSel,
   // event lines toward the block
   output logic [31:0] srcEvt,
   output logic [5:0] trapEvt
);
   timeunit 1ns;
   timeprecision 1ps;
   // each command becomes one single-cycle set pulse, never a held level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         srcEvt <= 32'h0000_0000;
         trapEvt <= 6'h00;
      end else begin
         srcEvt <= fire ? srcSel : 32'h0000_0000;
         trapEvt <= fire ? trapSel : 6'h00;
      end
   end
endmodule // icf_src_model
`default_nettype wire

// ==== verification/test_interrupt_control_flag_registers.sv ====
// self-checking bench for the interrupt flag register block
`default_nettype none
module test_interrupt_control_flag_registers;
   import icf_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, hsel, hwrite, hreadyout, hresp, trapPending, disable_countdown_active, fire;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, srcEvt, irqPending, srcSel;
   logic [4:0] extIrqPin, extEdgeSeen;
   logic [5:0] trapEvt, trapSel;
   int n_mismatch = 0;
   int n_checks = 0;
   icf_src_model icf_src_model_inst (.clk(clk), .rst_n(rst_n), .fire(fire), .srcSel(srcSel),
      .trapSel(trapSel), .srcEvt(srcEvt), .trapEvt(trapEvt));
   icf_flag_regs icf_flag_regs_inst (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .srcEvt(srcEvt), .extIrqPin(extIrqPin),
      .stackFaultEvt(trapEvt[0]), .oscFailEvt(trapEvt[1]), .usbAddrFaultEvt(trapEvt[2]),
      .dmaAddrFaultEvt(trapEvt[3]), .loopOverflowEvt(trapEvt[4]), .softHardTrapEvt(trapEvt[5]),
      .disableCountdownActive(disable_countdown_active), .irqPending(irqPending), .trapPending(trapPending),
      .extEdgeSeen(extEdgeSeen));
   // clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("ERROR %0t got %h exp %h", $time, got, exp);
         n_mismatch++;
      end
   endtask
   // one ahb transfer; ready and read data are taken at the rising edge that ends each phase
   task bus(input logic w, input logic [11:0] a, input logic [15:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {20'h00000, a};
      hwrite <= w;
      @(posedge clk);
      while (hreadyout !== 1'b1) begin
         @(posedge clk);
      end
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {16'h0000, d};
      @(posedge clk);
      while (hreadyout !== 1'b1) begin
         @(posedge clk);
      end
      r = hrdata;
   endtask
   task wr(input logic [11:0] a, input logic [15:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 16'h0000, r);
      chk(r, exp);
   endtask
   task idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // ask the source model for one pulse, then let flags and pending settle
   task pulse(input logic [31:0] s, input logic [5:0] t);
      fire <= 1'b1;
      srcSel <= s;
      trapSel <= t;
      @(posedge clk);
      fire <= 1'b0;
      idle(3);
   endtask
   task t_reset;
      rd(OFS_TRAP_STATUS, 32'h0);
      rd(OFS_GLOBAL_EDGE, 32'h8000);
      rd(OFS_SOFT_TRAP, 32'h0);
      rd(OFS_HARD_TRAP, 32'h0);
      rd(OFS_FLAGS0, 32'h0);
      rd(OFS_FLAGS1, 32'h0);
      rd(12'h020, 32'h0);
   endtask
   task t_ctrl;
      wr(OFS_GLOBAL_EDGE, 16'hffff);
      rd(OFS_GLOBAL_EDGE, 32'ha01f);
      disable_countdown_active <= 1'b1;
      rd(OFS_GLOBAL_EDGE, 32'he01f);
      disable_countdown_active <= 1'b0;
      wr(OFS_GLOBAL_EDGE, 16'h8000);
   endtask
   task t_traps;
      pulse(32'h0, 6'h1c);
      chk({31'h0, trapPending}, 32'h0);
      rd(OFS_SOFT_TRAP, 32'h70);
      wr(OFS_GLOBAL_EDGE, 16'ha000);
      idle(2);
      chk({31'h0, trapPending}, 32'h1);
      wr(OFS_GLOBAL_EDGE, 16'h8000);
      wr(OFS_SOFT_TRAP, 16'hffff);
      rd(OFS_SOFT_TRAP, 32'h70);
      wr(OFS_SOFT_TRAP, 16'h0000);
      rd(OFS_SOFT_TRAP, 32'h0);
      pulse(32'h0, 6'h23);
      chk({31'h0, trapPending}, 32'h1);
      wr(OFS_TRAP_STATUS, 16'h0007);
      rd(OFS_TRAP_STATUS, 32'h6);
      wr(OFS_HARD_TRAP, 16'hfffe);
      rd(OFS_HARD_TRAP, 32'h0);
      wr(OFS_TRAP_STATUS, 16'h0000);
      idle(2);
      chk({31'h0, trapPending}, 32'h0);
      wr(OFS_HARD_TRAP, 16'hffff);
      rd(OFS_HARD_TRAP, 32'h1);
      wr(OFS_HARD_TRAP, 16'h0000);
   endtask
   // every source sets only its own flag, and software clears it
   task t_flags;
      logic [11:0] a;
      for (int i = 0; i < 32; i++) begin
         a = (i < 16) ? OFS_FLAGS0 : OFS_FLAGS1;
         pulse(32'h1 << i, 6'h00);
         rd(a, 32'h1 << (i % 16));
         wr(a, 16'h0000);
         rd(a, 32'h0);
      end
      wr(OFS_FLAGS1, 16'h5a5a);
      rd(OFS_FLAGS1, 32'h5a5a);
      wr(OFS_FLAGS1, 16'h0000);
   endtask
   task t_pending;
      wr(OFS_ENABLE0, 16'h0008);
      pulse(32'h8, 6'h00);
      chk(irqPending, 32'h8);
      wr(OFS_GLOBAL_EDGE, 16'h0000);
      idle(2);
      chk(irqPending, 32'h0);
      wr(OFS_GLOBAL_EDGE, 16'h8000);
      idle(2);
      chk(irqPending, 32'h8);
      wr(OFS_FLAGS0, 16'h0000);
      wr(OFS_ENABLE0, 16'h0000);
   endtask
   // both polarities on each pin that owns a flag
   task t_ext;
      int unsigned pos[3];
      logic [11:0] a;
      logic [31:0] m;
      pos = '{FLAG_EXT0, FLAG_EXT1, FLAG_EXT2};
      extIrqPin <= 5'h18;
      idle(8);
      extIrqPin <= 5'h00;
      idle(8);
      for (int k = 0; k < 3; k++) begin
         a = (pos[k] < 16) ? OFS_FLAGS0 : OFS_FLAGS1;
         m = 32'h1 << (pos[k] % 16);
         extIrqPin <= 5'h01 << k;
         idle(8);
         rd(a, m);
         wr(a, 16'h0000);
         idle(8);
         rd(a, 32'h0);
         extIrqPin <= 5'h00;
         idle(8);
         rd(a, 32'h0);
         wr(OFS_GLOBAL_EDGE, 16'h8000 | (16'h1 << k));
         extIrqPin <= 5'h01 << k;
         idle(8);
         rd(a, 32'h0);
         extIrqPin <= 5'h00;
         idle(8);
         rd(a, m);
         wr(a, 16'h0000);
         wr(OFS_GLOBAL_EDGE, 16'h8000);
      end
   endtask
   // reset in mid-run drops every register and output back to its reset value
   task t_midreset;
      wr(OFS_GLOBAL_EDGE, 16'ha01f);
      wr(OFS_FLAGS0, 16'hffff);
      wr(OFS_ENABLE0, 16'hffff);
      pulse(32'h0, 6'h01);
      chk(irqPending, 32'h0000_ffff);
      chk({31'h0, trapPending}, 32'h1);
      rst_n <= 1'b0;
      idle(2);
      chk(irqPending, 32'h0);
      chk({31'h0, trapPending}, 32'h0);
      rst_n <= 1'b1;
      idle(1);
      t_reset;
      rd(OFS_ENABLE0, 32'h0);
   endtask
   // main sequence
   initial begin
      rst_n <= 1'b0;
      {hsel, hwrite, disable_countdown_active, fire} <= 4'h0;
      htrans <= 2'h0;
      {haddr, hwdata, srcSel} <= 96'h0;
      extIrqPin <= 5'h00;
      trapSel <= 6'h00;
      idle(2);
      rst_n <= 1'b1;
      idle(1);
      t_reset;
      t_ctrl;
      t_traps;
      t_flags;
      t_pending;
      t_ext;
      t_midreset;
      report_and_stop;
   end
   // watchdog
   initial begin
      idle(20000);
      n_mismatch++;
      report_and_stop;
   end
endmodule // test_interrupt_control_flag_registers
bind icf_flag_regs icf_props icf_props_inst (.clk(clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .extIrqPin(extIrqPin), .extEdgeSeen(extEdgeSeen), .stackFaultEvt(stackFaultEvt),
   .oscFailEvt(oscFailEvt), .softHardTrapEvt(softHardTrapEvt), .trapPending(trapPending));
`default_nettype wire
